// >>> core/stk_pkg.sv
package stk_pkg;

  // register byte offsets on the bus
  localparam logic [11:0] STK_CTRL_OFS = 12'h000;
  localparam logic [11:0] STK_SEL_OFS = 12'h004;
  localparam logic [11:0] STK_PTR_OFS = 12'h008;
  localparam logic [11:0] STK_STAT_OFS = 12'h00C;
  localparam logic [11:0] STK_LAST_OFS = 12'h010;

  // control register field positions
  localparam int STK_CTRL_CODE_D_BIT = 0;
  localparam int STK_CTRL_STACK_B_BIT = 1;

  // values after reset
  localparam logic [31:0] STK_PTR_RST = 32'h0000_0000;
  localparam logic [15:0] STK_SEL_RST = 16'h0000;
  localparam logic STK_CODE_D_RST = 1'b0;
  localparam logic STK_STACK_B_RST = 1'b0;

  // pointer steps in bytes for narrow and wide code segments
  localparam logic [31:0] STK_STEP_NARROW = 32'h0000_0002;
  localparam logic [31:0] STK_STEP_WIDE = 32'h0000_0004;

  // highest address a 16-bit stack access may form
  localparam logic [31:0] STK_ADDR16_MAX = 32'h0000_FFFF;

  // operations offered by the execution pipeline
  typedef enum logic [3:0] {
    STK_OP_PUSH,
    STK_OP_PUSH_SEL,
    STK_OP_POP,
    STK_OP_CALL,
    STK_OP_RET,
    STK_OP_FRAME_SETUP,
    STK_OP_FRAME_TEARDOWN,
    STK_OP_LOAD_SEL,
    STK_OP_LOAD_PTR,
    STK_OP_LOAD_FAR
  } stk_op_t;

  // where a popped item goes besides the response
  typedef enum logic [1:0] {
    STK_DEST_NONE,
    STK_DEST_SEL,
    STK_DEST_PTR
  } stk_dest_t;

  // one request from the pipeline
  typedef struct packed {
    stk_op_t op;
    stk_dest_t dest;
    logic addr_prefix;
    logic [31:0] data;
    logic [15:0] sel;
    logic [15:0] imm;
    logic [31:0] expl_addr;
  } stk_req_t;

  // one memory access toward the stack segment
  typedef struct packed {
    logic we;
    logic wide;
    logic [15:0] seg;
    logic [31:0] addr;
    logic [31:0] wdata;
  } stk_mem_t;

endpackage

// >>> core/stk_unit.sv
`timescale 1ns/1ns
module stk_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic req_valid,
  input wire stk_pkg::stk_req_t req,
  output logic req_ready,
  output logic resp_valid,
  output logic [31:0] resp_data,
  output logic [31:0] expl_addr,
  output logic expl_addr_32,
  output logic mem_valid,
  output stk_pkg::stk_mem_t mem,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  output logic [15:0] stack_sel,
  output logic [31:0] stack_ptr
);
  import stk_pkg::*;

  typedef enum logic [1:0] {
    STK_ST_IDLE,
    STK_ST_WRITE,
    STK_ST_READ
  } stk_state_t;

  stk_state_t state_reg; // sequencer state
  stk_op_t op_reg; // operation in flight
  stk_dest_t dest_reg; // destination of a pop in flight
  logic [15:0] imm_reg; // release or frame size in flight
  logic [31:0] sp_reg; // full stack pointer
  logic [15:0] ss_reg; // stack segment selector
  logic code_d_reg; // code segment size flag
  logic stack_b_reg; // stack segment size flag
  logic [31:0] last_addr_reg; // last stack address driven
  logic [31:0] step; // push/pop step in bytes
  logic [31:0] push_sp; // pointer after a plain push
  logic [31:0] sel_sp; // pointer after a selector push
  logic [31:0] sel_lo; // two bytes below the pointer, before rounding
  logic [31:0] tear_sp; // pointer loaded from the frame base at teardown, before the pop
  logic apb_wr; // write access phase
  logic apb_rd; // read access phase
  logic apb_hit; // address maps to a register
  logic accept; // pipeline request taken

  // add a signed delta; narrow stacks wrap inside the low half
  function automatic logic [31:0] sp_adj(input logic [31:0] sp,
                                         input logic [31:0] delta,
                                         input logic wide_addr);
    logic [15:0] lo;
    lo = sp[15:0] + delta[15:0];
    if (wide_addr) begin
      sp_adj = sp + delta;
    end else begin
      sp_adj = {sp[31:16], lo};
    end
  endfunction

  // top-of-stack address formed from the pointer
  function automatic logic [31:0] tos_addr(input logic [31:0] sp,
                                           input logic wide_addr);
    if (wide_addr) begin
      tos_addr = sp;
    end else begin
      tos_addr = sp & STK_ADDR16_MAX;
    end
  endfunction

  // load a value into the pointer with the current address size
  function automatic logic [31:0] sp_load(input logic [31:0] sp,
                                          input logic [31:0] val,
                                          input logic wide_addr);
    if (wide_addr) begin
      sp_load = val;
    end else begin
      sp_load = {sp[31:16], val[15:0]};
    end
  endfunction

  // step size follows the code segment flag, not the stack flag
  assign step = code_d_reg ? STK_STEP_WIDE :
                STK_STEP_NARROW;
  assign push_sp = sp_adj(sp_reg, -step, stack_b_reg);
  // selector push with the wide code segment flag takes a whole dword slot; the function
  // result is held in a net first since it cannot be part-selected
  assign sel_lo = sp_adj(sp_reg, -STK_STEP_NARROW, stack_b_reg);
  assign sel_sp = code_d_reg ? {sel_lo[31:2], 2'b00} : push_sp;
  assign tear_sp = sp_load(sp_reg, req.data, stack_b_reg);

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign apb_hit = (paddr == STK_CTRL_OFS) || (paddr == STK_SEL_OFS) ||
                   (paddr == STK_PTR_OFS) || (paddr == STK_STAT_OFS) ||
                   (paddr == STK_LAST_OFS);

  // stall the pipeline while software writes, so a bus write and a request are never taken in the same cycle
  assign req_ready = (state_reg == STK_ST_IDLE) && !apb_wr;
  assign accept = req_valid && req_ready;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign stack_sel = ss_reg;
  assign stack_ptr = sp_reg;

  // register reads; unmapped and reserved bits read zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_rd) begin
      case (paddr)
        STK_CTRL_OFS: begin
          prdata[STK_CTRL_CODE_D_BIT] = code_d_reg;
          prdata[STK_CTRL_STACK_B_BIT] = stack_b_reg;
        end
        STK_SEL_OFS: prdata = {16'h0000, ss_reg};
        STK_PTR_OFS: prdata = sp_reg;
        STK_STAT_OFS: prdata = {28'h000_0000, op_reg == STK_OP_PUSH_SEL,
                                state_reg == STK_ST_READ,
                                state_reg == STK_ST_WRITE,
                                state_reg != STK_ST_IDLE};
        STK_LAST_OFS: prdata = last_addr_reg;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // size flags are software controlled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_d_reg <= STK_CODE_D_RST;
      stack_b_reg <= STK_STACK_B_RST;
    end else if (apb_wr && paddr == STK_CTRL_OFS) begin
      code_d_reg <= pwdata[STK_CTRL_CODE_D_BIT];
      stack_b_reg <= pwdata[STK_CTRL_STACK_B_BIT];
    end
  end

  // explicit operand address size is independent of the stack size
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expl_addr <= 32'h0000_0000;
      expl_addr_32 <= 1'b0;
    end else if (accept) begin
      expl_addr_32 <= code_d_reg ^ req.addr_prefix;
      expl_addr <= (code_d_reg ^ req.addr_prefix) ? req.expl_addr :
                   (req.expl_addr & STK_ADDR16_MAX);
    end
  end

  // selector register: bus moves, pipeline loads and pops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_reg <= STK_SEL_RST;
    end else if (apb_wr && paddr == STK_SEL_OFS) begin
      ss_reg <= pwdata[15:0];
    end else if (accept && (req.op == STK_OP_LOAD_SEL ||
                            req.op == STK_OP_LOAD_FAR)) begin
      ss_reg <= req.sel;
    end else if (state_reg == STK_ST_READ && mem_ready &&
                 dest_reg == STK_DEST_SEL) begin
      ss_reg <= mem_rdata[15:0];
    end
  end

  // stack pointer; no alignment is checked anywhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= STK_PTR_RST;
    end else if (apb_wr && paddr == STK_PTR_OFS) begin
      sp_reg <= pwdata;
    end else if (accept) begin
      case (req.op)
        STK_OP_PUSH, STK_OP_CALL, STK_OP_FRAME_SETUP: begin
          sp_reg <= push_sp;
        end
        STK_OP_PUSH_SEL: sp_reg <= sel_sp;
        STK_OP_FRAME_TEARDOWN: sp_reg <= tear_sp;
        STK_OP_LOAD_PTR, STK_OP_LOAD_FAR: begin
          sp_reg <= sp_load(sp_reg, req.data, stack_b_reg);
        end
        default: sp_reg <= sp_reg;
      endcase
    end else if (state_reg == STK_ST_WRITE && mem_ready &&
                 op_reg == STK_OP_FRAME_SETUP) begin
      // room for locals is reserved only after the base is stored
      sp_reg <= sp_adj(sp_reg, -{16'h0000, imm_reg}, stack_b_reg);
    end else if (state_reg == STK_ST_READ && mem_ready) begin
      if (dest_reg == STK_DEST_PTR) begin
        sp_reg <= sp_load(sp_reg, mem_rdata, stack_b_reg);
      end else if (op_reg == STK_OP_RET) begin
        sp_reg <= sp_adj(sp_reg, step + {16'h0000, imm_reg},
                         stack_b_reg);
      end else begin
        sp_reg <= sp_adj(sp_reg, step, stack_b_reg);
      end
    end
  end

  // sequencer: pointer first on push, memory first on pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= STK_ST_IDLE;
      op_reg <= STK_OP_PUSH;
      dest_reg <= STK_DEST_NONE;
      imm_reg <= 16'h0000;
    end else begin
      case (state_reg)
        STK_ST_IDLE: begin
          if (accept) begin
            op_reg <= req.op;
            dest_reg <= req.dest;
            imm_reg <= req.imm;
            case (req.op)
              STK_OP_PUSH, STK_OP_PUSH_SEL, STK_OP_CALL,
              STK_OP_FRAME_SETUP: begin
                state_reg <= STK_ST_WRITE;
              end
              STK_OP_POP, STK_OP_RET, STK_OP_FRAME_TEARDOWN: begin
                state_reg <= STK_ST_READ;
              end
              default: state_reg <= STK_ST_IDLE;
            endcase
          end
        end
        STK_ST_WRITE: begin
          if (mem_ready) begin
            state_reg <= STK_ST_IDLE;
          end
        end
        STK_ST_READ: begin
          if (mem_ready) begin
            state_reg <= STK_ST_IDLE;
          end
        end
        default: state_reg <= STK_ST_IDLE;
      endcase
    end
  end

  // memory request; segment is always the stack selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_valid <= 1'b0;
      mem <= '0;
      last_addr_reg <= 32'h0000_0000;
    end else if (accept) begin
      mem.seg <= ss_reg;
      mem.wide <= code_d_reg;
      mem.wdata <= (req.op == STK_OP_PUSH_SEL) ?
                   {16'h0000, req.sel} : req.data;
      case (req.op)
        STK_OP_PUSH, STK_OP_CALL, STK_OP_FRAME_SETUP: begin
          mem_valid <= 1'b1;
          mem.we <= 1'b1;
          mem.addr <= tos_addr(push_sp, stack_b_reg);
          last_addr_reg <= tos_addr(push_sp, stack_b_reg);
        end
        STK_OP_PUSH_SEL: begin
          mem_valid <= 1'b1;
          mem.we <= 1'b1;
          mem.addr <= tos_addr(sel_sp, stack_b_reg);
          last_addr_reg <= tos_addr(sel_sp, stack_b_reg);
        end
        STK_OP_POP, STK_OP_RET: begin
          mem_valid <= 1'b1;
          mem.we <= 1'b0;
          mem.addr <= tos_addr(sp_reg, stack_b_reg);
          last_addr_reg <= tos_addr(sp_reg, stack_b_reg);
        end
        STK_OP_FRAME_TEARDOWN: begin
          mem_valid <= 1'b1;
          mem.we <= 1'b0;
          mem.addr <= tos_addr(tear_sp, stack_b_reg);
          last_addr_reg <= tos_addr(tear_sp, stack_b_reg);
        end
        default: mem_valid <= 1'b0;
      endcase
    end else if (mem_valid && mem_ready) begin
      mem_valid <= 1'b0;
    end
  end

  // completion pulse; popped data is handed back with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid <= 1'b0;
      resp_data <= 32'h0000_0000;
    end else begin
      resp_valid <= 1'b0;
      if (accept && (req.op == STK_OP_LOAD_SEL ||
                     req.op == STK_OP_LOAD_PTR ||
                     req.op == STK_OP_LOAD_FAR)) begin
        resp_valid <= 1'b1;
      end else if (state_reg == STK_ST_WRITE && mem_ready) begin
        resp_valid <= 1'b1;
      end else if (state_reg == STK_ST_READ && mem_ready) begin
        resp_valid <= 1'b1;
        resp_data <= mem_rdata;
      end
    end
  end

endmodule // stk_unit

// >>> test/stk_mem_model.sv
`timescale 1ns/1ns
module stk_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] delay,
  input wire logic mem_valid,
  input wire stk_pkg::stk_mem_t mem,
  output logic mem_ready,
  output logic [31:0] mem_rdata
);
  import stk_pkg::*;
  // word store indexed by the low address bits; it aliases every 256
  // bytes, so tests must pop an item before pushing over its alias
  logic [31:0] store [0:255];
  logic [255:0] seen; // entries written since reset
  logic [3:0] wait_cnt; // cycles already spent on the open access
  stk_mem_t last; // copy of the last completed access
  // answer after delay cycles; read data toggles outside an answer so a
  // design that samples it at the wrong edge cannot see a stale match
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ready <= 1'b0;
      mem_rdata <= 32'h5A5A_5A5A;
      wait_cnt <= 4'h0;
      last <= '0;
      seen <= '0;
    end else if (mem_valid && mem_ready) begin
      // access completes here, write lands at this edge only
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= 4'h0;
      last <= mem;
      if (mem.we) begin
        store[mem.addr[7:0]] <= mem.wdata;
        seen[mem.addr[7:0]] <= 1'b1;
      end
    end else if (mem_valid && wait_cnt >= delay) begin
      mem_ready <= 1'b1;
      mem_rdata <= seen[mem.addr[7:0]] ? store[mem.addr[7:0]] : ~mem.addr;
    end else begin
      wait_cnt <= mem_valid ? wait_cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // stk_mem_model

// >>> test/stk_unit_props.sv
`timescale 1ns/1ns
module stk_unit_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic [31:0] expl_addr,
  input wire logic expl_addr_32,
  input wire logic mem_valid,
  input wire stk_pkg::stk_mem_t mem,
  input wire logic mem_ready,
  input wire logic [15:0] stack_sel,
  input wire logic [31:0] stack_ptr
);
  import stk_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped; // word-aligned offset inside the register map
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= STK_LAST_OFS);
  // access phase, open memory access, completed memory access
  sequence s_apb_acc; psel && penable; endsequence
  sequence s_mem_wait; mem_valid && !mem_ready; endsequence
  sequence s_mem_done; mem_valid && mem_ready; endsequence
  chk_apb_no_wait: assert property (s_apb_acc |-> pready)
    else $error("apb access not answered at once");
  chk_unmapped_err: assert property (s_apb_acc ##0 !mapped |->
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  chk_rdata_idle: assert property (!(psel && penable) |->
    prdata == 32'h0 && !pslverr) else $error("bus outputs outside access");
  chk_push_new_top: assert property (
    mem_valid && mem.we |-> mem.addr[15:0] == stack_ptr[15:0])
    else $error("push not written at lowered pointer");
  chk_pop_old_top: assert property (
    mem_valid && !mem.we |-> mem.addr[15:0] == stack_ptr[15:0])
    else $error("pop not read at current pointer");
  chk_pop_ptr_hold: assert property (s_mem_wait ##0 !mem.we |=>
    $stable(stack_ptr)) else $error("pointer moved before pop read");
  chk_seg_current: assert property (
    mem_valid |-> mem.seg == stack_sel)
    else $error("access outside current stack");
  chk_mem_held: assert property (s_mem_wait |=> mem_valid && $stable(mem))
    else $error("memory request changed before answer");
  chk_done_resp: assert property (
    s_mem_done |=> resp_valid && !mem_valid)
    else $error("no response after memory answer");
  chk_busy_refuse: assert property (mem_valid |-> !req_ready)
    else $error("request taken while busy");
  chk_expl_mask: assert property (
    !expl_addr_32 |-> expl_addr[31:16] == 16'h0000)
    else $error("narrow explicit address not masked");
  chk_wide_addr: assert property (
    mem_valid && mem.addr[31:16] != 16'h0000 |-> mem.addr == stack_ptr)
    else $error("wide stack address not full pointer");
endmodule // stk_unit_props
bind stk_unit stk_unit_props u_stk_unit_props (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .req_ready(req_ready), .resp_valid(resp_valid), .expl_addr(expl_addr),
  .expl_addr_32(expl_addr_32), .mem_valid(mem_valid), .mem(mem),
  .mem_ready(mem_ready), .stack_sel(stack_sel), .stack_ptr(stack_ptr));

// >>> test/stk_unit_tb_top.sv
`timescale 1ns/1ns
module stk_unit_tb_top;
  import stk_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid;
  logic req_ready, resp_valid, expl_addr_32, mem_valid, mem_ready, pf_g;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, resp_data, expl_addr, mem_rdata, ea_g;
  logic [31:0] stack_ptr, rd_q;
  logic [15:0] stack_sel;
  logic [3:0] mem_delay; // memory answer latency in cycles
  logic rd_e; // error flag of the last bus access
  stk_req_t req;
  stk_mem_t mem;
  int err_count, checks, cyc;
  stk_unit u_stk_unit (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_data(resp_data), .expl_addr(expl_addr),
    .expl_addr_32(expl_addr_32), .mem_valid(mem_valid), .mem(mem),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .stack_sel(stack_sel),
    .stack_ptr(stack_ptr));
  stk_mem_model u_stk_mem_model (.pclk(pclk), .presetn(presetn),
    .delay(mem_delay), .mem_valid(mem_valid), .mem(mem),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  // 20 MHz clock
  always #25 pclk = ~pclk;
  // hang guard, far above the few hundred cycles the tests take
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer: setup, access held until pready at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one pipeline request, held until taken, then wait for the response
  task op(input stk_op_t o, input stk_dest_t dt, input logic [31:0] d,
    input logic [15:0] s, input logic [15:0] im);
    @(posedge pclk);
    req_valid <= 1'b1;
    req <= '{o, dt, pf_g, d, s, im, ea_g};
    @(posedge pclk);
    while (req_ready !== 1'b1) @(posedge pclk);
    req_valid <= 1'b0;
    @(posedge pclk);
    while (resp_valid !== 1'b1) @(posedge pclk);
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; req_valid = 0; req = '0; mem_delay = 4'h3;
    pf_g = 0; ea_g = '0; err_count = 0; checks = 0; cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset pointer value, read-only status, unmapped offset
    apb(1'b0, STK_PTR_OFS, 32'h0);
    cmp("ptr rst", STK_PTR_RST, rd_q);
    apb(1'b1, STK_STAT_OFS, 32'hF);
    apb(1'b0, STK_STAT_OFS, 32'h0);
    cmp("stat", 32'h0, rd_q);
    apb(1'b0, 12'h020, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, rd_e});
    $display("reset test done");
    // wide stack: size flags, selector, pointer in that order
    apb(1'b1, STK_CTRL_OFS, 32'h3);
    apb(1'b1, STK_SEL_OFS, 32'h0123);
    apb(1'b1, STK_PTR_OFS, 32'h1000);
    op(STK_OP_PUSH, STK_DEST_NONE, 32'hDEAD_BEEF, 16'h0, 16'h0);
    cmp("sp push", 32'h0FFC, stack_ptr);
    cmp("push addr", 32'h0FFC, u_stk_mem_model.last.addr);
    cmp("push seg", 32'h0123, {16'h0, u_stk_mem_model.last.seg});
    cmp("push wide", 32'h1, 32'(u_stk_mem_model.last.wide));
    apb(1'b0, STK_LAST_OFS, 32'h0);
    cmp("last", 32'h0FFC, rd_q);
    op(STK_OP_CALL, STK_DEST_NONE, 32'h1111_0000, 16'h0, 16'h0);
    cmp("sp call", 32'h0FF8, stack_ptr);
    op(STK_OP_POP, STK_DEST_NONE, 32'h0, 16'h0, 16'h0);
    cmp("pop data", 32'h1111_0000, resp_data);
    cmp("sp pop", 32'h0FFC, stack_ptr);
    op(STK_OP_RET, STK_DEST_NONE, 32'h0, 16'h0, 16'h0004);
    cmp("ret data", 32'hDEAD_BEEF, resp_data);
    cmp("sp ret", 32'h1004, stack_ptr);
    op(STK_OP_FRAME_SETUP, STK_DEST_NONE, 32'h55, 16'h0, 16'h0010);
    cmp("sp setup", 32'h0FF0, stack_ptr);
    op(STK_OP_FRAME_TEARDOWN, STK_DEST_NONE, 32'h1000, 16'h0, 16'h0);
    cmp("teardown", 32'h55, resp_data);
    cmp("sp tear", 32'h1004, stack_ptr);
    $display("wide stack test done");
    // misaligned pointer, then selector push realigns
    mem_delay <= 4'h0;
    apb(1'b1, STK_PTR_OFS, 32'h1003);
    op(STK_OP_PUSH, STK_DEST_NONE, 32'h7, 16'h0, 16'h0);
    cmp("sp odd", 32'h0FFF, stack_ptr);
    op(STK_OP_PUSH_SEL, STK_DEST_NONE, 32'h0, 16'h0123, 16'h0);
    cmp("sp sel", 32'h0FFC, stack_ptr);
    cmp("sel wdata", 32'h0000_0123, u_stk_mem_model.last.wdata);
    apb(1'b0, STK_STAT_OFS, 32'h0);
    cmp("stat sel", 32'h8, rd_q);
    $display("alignment test done");
    // narrow addressing wraps in the low half only
    apb(1'b1, STK_CTRL_OFS, 32'h0);
    apb(1'b1, STK_PTR_OFS, 32'hABCD_0000);
    op(STK_OP_PUSH, STK_DEST_NONE, 32'h1234, 16'h0, 16'h0);
    cmp("sp n16", 32'hABCD_FFFE, stack_ptr);
    cmp("addr n16", 32'hFFFE, u_stk_mem_model.last.addr);
    op(STK_OP_POP, STK_DEST_NONE, 32'h0, 16'h0, 16'h0);
    cmp("pop n16", 32'h1234, {16'h0, resp_data[15:0]});
    cmp("sp n16b", 32'hABCD_0000, stack_ptr);
    apb(1'b1, STK_CTRL_OFS, 32'h1);
    apb(1'b1, STK_PTR_OFS, 32'h0001_0002);
    op(STK_OP_PUSH, STK_DEST_NONE, 32'h9, 16'h0, 16'h0);
    cmp("sp w16", 32'h0001_FFFE, stack_ptr);
    apb(1'b1, STK_CTRL_OFS, 32'h2);
    apb(1'b1, STK_PTR_OFS, 32'h2000_0000);
    op(STK_OP_PUSH, STK_DEST_NONE, 32'h9, 16'h0, 16'h0);
    cmp("addr n32", 32'h1FFF_FFFE, u_stk_mem_model.last.addr);
    $display("address size test done");
    // explicit operand size for each code flag and prefix
    ea_g = 32'h89AB_CDEF;
    for (int i = 0; i < 4; i++) begin
      pf_g = i[1];
      apb(1'b1, STK_CTRL_OFS, {30'h0, 1'b1, i[0]});
      op(STK_OP_PUSH, STK_DEST_NONE, 32'h0, 16'h0, 16'h0);
      cmp("expl size", 32'(i[0] ^ i[1]), 32'(expl_addr_32));
      cmp("expl addr", i[0] != i[1] ? ea_g : 32'hCDEF, expl_addr);
    end
    $display("explicit address test done");
    // direct, far and popped loads of selector and pointer
    op(STK_OP_LOAD_FAR, STK_DEST_NONE, 32'h3000, 16'h0789, 16'h0);
    cmp("far sel", 32'h0789, {16'h0, stack_sel});
    cmp("far ptr", 32'h3000, stack_ptr);
    op(STK_OP_LOAD_SEL, STK_DEST_NONE, 32'h0, 16'h0456, 16'h0);
    cmp("load sel", 32'h0456, {16'h0, stack_sel});
    op(STK_OP_LOAD_PTR, STK_DEST_NONE, 32'h2000, 16'h0, 16'h0);
    cmp("load ptr", 32'h2000, stack_ptr);
    op(STK_OP_PUSH, STK_DEST_NONE, 32'h0999, 16'h0, 16'h0);
    op(STK_OP_POP, STK_DEST_SEL, 32'h0, 16'h0, 16'h0);
    cmp("pop sel", 32'h0999, {16'h0, stack_sel});
    op(STK_OP_PUSH, STK_DEST_NONE, 32'h4000, 16'h0, 16'h0);
    op(STK_OP_POP, STK_DEST_PTR, 32'h0, 16'h0, 16'h0);
    cmp("pop ptr", 32'h4000, stack_ptr);
    $display("load test done");
    wrap_up();
  end
endmodule // stk_unit_tb_top
